// [hw/gdrt_pkg.sv]
/*
 * Package for the gear-down and refresh command block: command field
 * layout, reset values and cycle counts.
 * Assumes a 250 MHz ref_clk; times are converted to cycles here.
 */
package gdrt_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int REFRESH_CYCLE_TIME_NS = 350;
    localparam int REFRESH_CYCLE_CNT =
        (REFRESH_CYCLE_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int CMD_GEAR_CNT = 8;
    localparam int DLL_LOCK_CNT = 1024;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    localparam logic [15:0] ROW_RESET = 16'h0000;
    localparam logic [15:0] ROW_ONE = 16'h0001;
    localparam int GEAR_BIT_POS = 3;

    // ------------------------------------------------------------
    // Command bus bundle, as sampled at a link clock rising edge
    // ------------------------------------------------------------
    typedef struct packed {
        logic chip_select_n;
        logic activate_n;
        logic row_strobe_a16;
        logic column_strobe_a15;
        logic write_enable_a14;
        logic mode_reg_sel;   // Write targets mode_reg_three
        logic [13:0] addr;
    } gdrt_cmd_t;

    // Gear state
    typedef enum logic [4:0] {
        GS_HALF = 5'b00001,
        GS_SYNC = 5'b00010,
        GS_CMDG = 5'b00100,
        GS_DLLW = 5'b01000,
        GS_QUAR = 5'b10000
    } gdrt_gear_t;

    // Status bundle
    typedef struct packed {
        logic quarter_rate;
        logic cmd_ok;
        logic dll_cmd_ok;
        logic refresh_busy;
        logic banks_idle;
    } gdrt_stat_t;
endpackage

// [hw/gdrt_sync.sv]
/*
 * Two-flop synchroniser with rising-edge pulse on the synced level.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
module gdrt_sync
(
    input wire logic clk, // Sampling clock
    input wire logic rst, // Sync reset
    input wire logic ce, // Clock enable
    input wire logic din, // Async level
    output logic dout, // Synced level
    output logic rise // One-cycle rising pulse
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Only s2 and s3 feed the edge detector
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else if (ce)
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign dout = s2_r;
    assign rise = ce & s2_r & ~s3_r;
endmodule

// [hw/gdrt_core.sv]
/*
 * Device-side gear-down mode and refresh command logic.
 * Assumes the link clock and command pins come from the controller and
 * are asynchronous; all are synchronised before use.
 */
`timescale 1ns/1ps
module gdrt_core
    import gdrt_pkg::*;
(
    input wire logic ref_clk, // Block clock, 250 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic clk_en, // Freezes all state when low
    input wire logic link_clk, // Controller command clock pin
    input wire gdrt_cmd_t cmd_pins, // Command bus pins
    input wire logic self_refresh_active, // Device in self refresh
    input wire logic exit_delay_done, // Exit delay per mode_reg_four
    output gdrt_stat_t status, // Gear and refresh status
    output logic [15:0] refresh_row, // Internal refresh row counter
    output logic refresh_pulse // One pulse per decoded refresh
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic lclk_rise;
    logic sr_lvl;
    logic xd_lvl;
    gdrt_cmd_t cmd_s1_r;
    gdrt_cmd_t cmd_s2_r;

    gdrt_sync u_lclk
    (
        .clk(ref_clk),
        .rst(rst),
        .ce(clk_en),
        .din(link_clk),
        .dout(),
        .rise(lclk_rise)
    );

    gdrt_sync u_sr
    (
        .clk(ref_clk),
        .rst(rst),
        .ce(clk_en),
        .din(self_refresh_active),
        .dout(sr_lvl),
        .rise()
    );

    gdrt_sync u_xd
    (
        .clk(ref_clk),
        .rst(rst),
        .ce(clk_en),
        .din(exit_delay_done),
        .dout(xd_lvl),
        .rise()
    );

    // Command pins pass two flops; the edge pulse lines up with stage two
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cmd_s1_r <= '1;
            cmd_s2_r <= '1;
        end
        else if (clk_en)
        begin
            cmd_s1_r <= cmd_pins;
            cmd_s2_r <= cmd_s1_r;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        gdrt_gear_t gear;
        logic [CNT_W-1:0] gear_cnt;
        logic [CNT_W-1:0] dll_cnt;
        logic [CNT_W-1:0] rfc_cnt;
        logic [15:0] row;
        logic ref_p;
        logic sr_seen;
    } gdrt_state_t;

    gdrt_state_t st_r;
    gdrt_state_t st_nxt;

    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
    endfunction

    // Command decode, sampled on a link rising edge
    logic cmd_edge;
    logic is_ref;
    logic is_gear_wr;
    logic is_sync;
    assign cmd_edge = lclk_rise;
    assign is_ref = cmd_edge & ~cmd_s2_r.chip_select_n &
        cmd_s2_r.activate_n & ~cmd_s2_r.row_strobe_a16 &
        ~cmd_s2_r.column_strobe_a15 & cmd_s2_r.write_enable_a14;
    // Mode write: all strobes low, activate high
    assign is_gear_wr = cmd_edge & ~cmd_s2_r.chip_select_n &
        cmd_s2_r.activate_n & ~cmd_s2_r.row_strobe_a16 &
        ~cmd_s2_r.column_strobe_a15 & ~cmd_s2_r.write_enable_a14 &
        cmd_s2_r.mode_reg_sel & cmd_s2_r.addr[GEAR_BIT_POS];
    // Sync pulse: single-cycle select with no-op encoding
    assign is_sync = cmd_edge & ~cmd_s2_r.chip_select_n &
        cmd_s2_r.activate_n & cmd_s2_r.row_strobe_a16 &
        cmd_s2_r.column_strobe_a15 & cmd_s2_r.write_enable_a14;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ref_p = 1'b0;
        st_nxt.rfc_cnt = dec_sat(st_r.rfc_cnt);
        st_nxt.gear_cnt = dec_sat(st_r.gear_cnt);
        st_nxt.dll_cnt = dec_sat(st_r.dll_cnt);
        if (sr_lvl)
            st_nxt.sr_seen = 1'b1;
        // Every refresh is taken; the debt is kept outside
        if (is_ref)
        begin
            st_nxt.row = st_r.row + ROW_ONE;
            st_nxt.ref_p = 1'b1;
            st_nxt.rfc_cnt = CNT_W'(REFRESH_CYCLE_CNT);
        end
        case (st_r.gear)
            GS_HALF:
            begin
                // Entry only at init or after SR exit delay
                // Exit gate, normal or abort delay
                if (is_gear_wr && !sr_lvl &&
                    (!st_r.sr_seen || xd_lvl))
                begin
                    st_nxt.gear = GS_SYNC;
                end
            end
            GS_SYNC:
            begin
                // Sync pulse arms command gear delay
                if (is_sync)
                begin
                    st_nxt.gear = GS_CMDG;
                    st_nxt.gear_cnt = CNT_W'(CMD_GEAR_CNT);
                    st_nxt.dll_cnt = CNT_W'(DLL_LOCK_CNT);
                end
            end
            GS_CMDG:
            begin
                if (st_r.gear_cnt == CNT_ZERO)
                    st_nxt.gear = GS_DLLW;
            end
            GS_DLLW:
            begin
                // DLL commands wait for lock time
                if (st_r.dll_cnt == CNT_ZERO)
                    st_nxt.gear = GS_QUAR;
            end
            GS_QUAR:
            begin
            end
            default:
                st_nxt.gear = GS_HALF;
        endcase
        if (sr_lvl)
            st_nxt.gear = GS_HALF;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r.gear <= GS_HALF;
            st_r.gear_cnt <= CNT_ZERO;
            st_r.dll_cnt <= CNT_ZERO;
            st_r.rfc_cnt <= CNT_ZERO;
            st_r.row <= ROW_RESET;
            st_r.ref_p <= 1'b0;
            st_r.sr_seen <= 1'b0;
        end
        else if (clk_en)
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Status decodes the registered gear state and refresh count; quarter rate only
    // once the command gear delay has run out
    always_comb
    begin
        status.quarter_rate = (st_r.gear == GS_DLLW) ||
            (st_r.gear == GS_QUAR);
        status.cmd_ok = (st_r.gear == GS_HALF) ||
            (st_r.gear == GS_DLLW) || (st_r.gear == GS_QUAR);
        status.dll_cmd_ok = (st_r.gear == GS_HALF) ||
            (st_r.gear == GS_QUAR);
        status.refresh_busy = (st_r.rfc_cnt != CNT_ZERO);
        status.banks_idle = (st_r.rfc_cnt == CNT_ZERO);
    end

    assign refresh_row = st_r.row;
    assign refresh_pulse = st_r.ref_p;
endmodule

// [tb/gdrt_core_properties.sv]
/* Port checker for gdrt_core: refresh, row counter and gear timing.
   Assumes clk_en stays high through a refresh cycle and command pins
   hold across a link edge. */
`timescale 1ns/1ps
module gdrt_core_properties
    import gdrt_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic clk_en, // Enable
    input wire logic link_clk, // Link clock
    input wire gdrt_cmd_t cmd_pins, // Pins
    input wire logic self_refresh_active, // Self refresh
    input wire logic exit_delay_done, // Exit delay
    input wire gdrt_stat_t status, // Status
    input wire logic [15:0] refresh_row, // Row
    input wire logic refresh_pulse // Pulse
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    int busy_n;
    int gap_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Busy length, and quarter-rate cycles still waiting for the DLL
    always_ff @(posedge ref_clk)
    begin
        busy_n <= (rst || !status.refresh_busy) ? 0 : busy_n + 1;
        gap_n <= (status.quarter_rate && !status.dll_cmd_ok) ? gap_n + 1 : 0;
    end
    sequence s_sr_held;
        self_refresh_active [*5];
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_half_rate: assert property ($fell(rst) |->
        !status.quarter_rate && status.dll_cmd_ok &&
        refresh_row == ROW_RESET)
        else $error("not half rate after reset");
    a_pulse_single: assert property (refresh_pulse |=>
        !refresh_pulse)
        else $error("refresh pulse too long");
    a_ref_decode: assert property (refresh_pulse |->
        $past(cmd_pins[19:15], 4) == 5'h09)
        else $error("pulse without refresh");
    a_row_step: assert property (refresh_pulse |->
        refresh_row == $past(refresh_row) + ROW_ONE)
        else $error("row not stepped");
    a_row_hold: assert property (!refresh_pulse |->
        $stable(refresh_row))
        else $error("row moved without refresh");
    a_busy_start: assert property (refresh_pulse |->
        status.refresh_busy && !status.banks_idle)
        else $error("busy not raised");
    a_busy_span: assert property ($fell(status.refresh_busy) |->
        busy_n == REFRESH_CYCLE_CNT && status.banks_idle)
        else $error("refresh cycle length wrong");
    a_sr_half: assert property (s_sr_held |->
        !status.quarter_rate)
        else $error("quarter rate in self refresh");
    a_gear_ready: assert property ($rose(status.quarter_rate) |->
        status.cmd_ok && !status.dll_cmd_ok)
        else $error("gear entry status");
    a_dll_gap: assert property ($rose(status.dll_cmd_ok) &&
        status.quarter_rate |-> gap_n == DLL_LOCK_CNT - CMD_GEAR_CNT)
        else $error("dll wait wrong");
endmodule
bind gdrt_core gdrt_core_properties chk_u (.*);

// [tb/gdrt_ctrl_model.sv]
/* Controller model: one command per link clock period.
   The link clock stands still between frames; released pins invert. */
`timescale 1ns/1ps
module gdrt_ctrl_model
    import gdrt_pkg::*;
(
    output logic link_clk, // Link clock
    output gdrt_cmd_t cmd_pins // Command pins
);
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    initial
    begin
        link_clk = 1'b0;
        cmd_pins = '1;
    end
    // frames are even and back to back; inverted pins, not deselects, fill each tail
    task automatic send(input gdrt_cmd_t c);
        cmd_pins = c;
        #21.3 link_clk = 1'b1;
        #40 link_clk = 1'b0;
        #18.7 cmd_pins = ~c; // No pull; inverse so stale data never passes
    endtask
endmodule

// [tb/gdrt_core_tb.sv]
/* Bench for gdrt_core: random refreshes, decode corners and gear-down
   entry at init and after self refresh, through gdrt_ctrl_model. */
`timescale 1ns/1ps
module gdrt_core_tb
    import gdrt_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic link_clk;
    logic sr_on = 1'b0;
    logic exit_done = 1'b1;
    logic ce = 1'b1;
    gdrt_cmd_t cmd_pins;
    gdrt_stat_t status;
    logic [15:0] refresh_row;
    logic refresh_pulse;
    logic [15:0] exp_row = 16'h0000;
    logic [15:0] n_pulse = 16'h0000;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 ref_clk = ~ref_clk;
    gdrt_ctrl_model ctl_u (.link_clk(link_clk), .cmd_pins(cmd_pins));
    gdrt_core dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(ce),
        .link_clk(link_clk), .cmd_pins(cmd_pins),
        .self_refresh_active(sr_on), .exit_delay_done(exit_done),
        .status(status), .refresh_row(refresh_row),
        .refresh_pulse(refresh_pulse));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] e,
        input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic gdrt_cmd_t mk(input logic [4:0] lv,
        input logic [14:0] rest);
        return {lv, rest};
    endfunction
    task automatic wait_bit(input int b, input int lim);
        for (int k = 0; k < lim && status[b] !== 1'b1; k++)
            @(negedge ref_clk);
    endtask
    // Gear write to mode_reg_three, a deselect, then the sync
    task automatic gear;
        ctl_u.send(mk(5'h08, 15'h4008));
        // Deselect frame puts the sync two clocks on
        ctl_u.send(mk(5'h1f, 15'h0000));
        ctl_u.send(mk(5'h0f, 15'h0000));
        repeat (40) @(negedge ref_clk);
    endtask
    // Hang guard; the full run needs about 2200 cycles
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            failures++;
            end_of_test();
        end
    end
    // Count every refresh pulse while it stands
    always @(negedge ref_clk)
    begin
        if (refresh_pulse === 1'b1)
            n_pulse <= n_pulse + 16'h0001;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(30));
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk("status", 16'h000d, status);
        for (int n = 0; n < 6; n++)
        begin
            ctl_u.send(mk(5'h09, 15'($urandom)));
            exp_row++;
            chk("row", exp_row, refresh_row);
            chk("pulses", exp_row, n_pulse);
            chk("busy", 16'h0001, status.refresh_busy);
            repeat (90) @(negedge ref_clk);
            chk("idle", 16'h0001, status[1:0]);
        end
        // One flipped strobe per pass: none may refresh
        for (int b = 0; b < 5; b++)
        begin
            ctl_u.send(mk(5'h09 ^ (5'h01 << b), 15'h0000));
            repeat (10) @(negedge ref_clk);
            chk("row", exp_row, refresh_row);
        end
        // Clock enable low: a refresh frame must leave no trace
        ce = 1'b0;
        ctl_u.send(mk(5'h09, 15'h0000));
        ce = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("row", exp_row, refresh_row);
        chk("pulses", exp_row, n_pulse);
        // Parity, latency modes and power-down unused
        gear();
        chk("quarter", 16'h0001, status.quarter_rate);
        chk("cmd_ok", 16'h0001, status.cmd_ok);
        chk("dll", 16'h0000, status.dll_cmd_ok);
        wait_bit(2, 1100);
        chk("dll", 16'h0001, status.dll_cmd_ok);
        // Quarter rate is left only through self refresh or reset
        sr_on = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("quarter", 16'h0000, status.quarter_rate);
        gear();
        chk("quarter", 16'h0000, status.quarter_rate);
        sr_on = 1'b0;
        exit_done = 1'b0;
        // Exit delay still running: the gear write is refused
        gear();
        chk("quarter", 16'h0000, status.quarter_rate);
        exit_done = 1'b1;
        gear();
        chk("quarter", 16'h0001, status.quarter_rate);
        end_of_test();
    end
endmodule
